/* common/wcbm_defines.svh */
// constants for the burst-chop-four write check mapper
`ifndef WCBM_DEFINES_SVH
`define WCBM_DEFINES_SVH
// ==========================================================
// burst shape and check polynomial
`define WCBM_CRC_POLY    8'h07
`define WCBM_DATA_LAST   4'h3
`define WCBM_CRC_BEAT0   4'h8
`define WCBM_BURST_LAST  4'h9
// ==========================================================
// device-end register map (byte addresses)
`define WCBM_DEV_CFG     8'h00
`define WCBM_DEV_STATUS  8'h04
`define WCBM_DEV_MASK    8'h08
`define WCBM_DEV_RESULT  8'h0C
// ==========================================================
// controller-end register map (byte addresses)
`define WCBM_HST_DATA_LO 8'h00
`define WCBM_HST_DATA_HI 8'h04
`define WCBM_HST_MI      8'h08
`define WCBM_HST_CTRL    8'h0C
`define WCBM_HST_STATUS  8'h10
`define WCBM_HST_MASK    8'h14
`define WCBM_HST_CRC     8'h18
// ==========================================================
// fields and reset values
`define WCBM_CFG_ORG_LSB 0
`define WCBM_CFG_MI_BIT  2
`define WCBM_CTRL_HALF   3
`define WCBM_CTRL_GO     4
`define WCBM_ST_DONE     0
`define WCBM_ST_ERR      1
`define WCBM_ST_BUSY     2
`define WCBM_RES_HALF    16
`define WCBM_CFG_RST     3'h1
`define WCBM_MASK_RST    2'h0
`endif

/* common/wcbm_pkg.sv */
// types and shared mapping / check functions for both link ends
`include "wcbm_defines.svh"
package wcbm_pkg;
	// ==========================================================
	// types
	typedef enum logic [1:0] {
		WCBM_ORG_X4  = 2'b00,
		WCBM_ORG_X8  = 2'b01,
		WCBM_ORG_X16 = 2'b10
	} wcbm_org_t;
	// lanes [15:0] data, [16] lower mask/inversion, [17] upper mask/inversion
	typedef logic [17:0]       wcbm_beat_t;
	typedef logic [3:0][17:0]  wcbm_beats_t;

	// ==========================================================
	// serial form of x^8+x^2+x+1, first bit d[71], start value zero
	function automatic logic [7:0] wcbm_crc8(input logic [71:0] d);
		logic [7:0] c;
		logic       fb;
		c = 8'h00;
		for (int i = 71; i >= 0; i--) begin
			fb = c[7] ^ d[i];
			c = {c[6:0], 1'b0} ^ ({8{fb}} & `WCBM_CRC_POLY);
		end
		return c;
	endfunction

	// ==========================================================
	// tree inputs: index = tree*72 + lane*8 + half*4 + transfer, unused positions one
	function automatic logic [143:0] wcbm_tree_in(input wcbm_beats_t b, input logic half,
			input wcbm_org_t org, input logic mi_en);
		logic [143:0] d;
		logic         live;
		int           src;
		d = '1;
		for (int tr = 0; tr < 2; tr++) begin
			for (int ln = 0; ln < 9; ln++) begin
				src = (ln < 8) ? tr * 8 + ln : 16 + tr;
				if (ln < 8) begin
					live = (tr == 0 && (org != WCBM_ORG_X4 || ln < 4)) ||
						(tr == 1 && org == WCBM_ORG_X16);
				end else begin
					live = mi_en && ((tr == 0) ? org != WCBM_ORG_X4 : org == WCBM_ORG_X16);
				end
				for (int t = 0; t < 4; t++) begin
					if (live) begin
						d[tr * 72 + ln * 8 + (half ? 4 : 0) + t] = b[t][src];
					end
				end
			end
		end
		return d;
	endfunction

	// ==========================================================
	// check transfers 8 and 9; everything not carrying a check bit is one
	function automatic wcbm_beat_t wcbm_crc_beat(input logic [15:0] crc, input wcbm_org_t org,
			input logic second);
		wcbm_beat_t b;
		b = '1;
		if (org == WCBM_ORG_X4) begin
			b[3:0] = second ? crc[7:4] : crc[3:0];
		end else if (!second) begin
			b[7:0] = crc[7:0];
			if (org == WCBM_ORG_X16) begin
				b[15:8] = crc[15:8];
			end
		end
		return b;
	endfunction
endpackage

/* common/wcbm_if.sv */
// write burst link between controller end and device end
`timescale 1ns/1ps
interface wcbm_if;
	logic        link_valid;
	logic        link_first;
	logic        burst_half_select_bit;
	logic [15:0] link_dq;
	logic        lower_mask_inversion_lane;
	logic        upper_mask_inversion_lane;

	modport ctrl (
		output link_valid,
		output link_first,
		output burst_half_select_bit,
		output link_dq,
		output lower_mask_inversion_lane,
		output upper_mask_inversion_lane
	);
	modport dram (
		input link_valid,
		input link_first,
		input burst_half_select_bit,
		input link_dq,
		input lower_mask_inversion_lane,
		input upper_mask_inversion_lane
	);
endinterface

/* verilog/wcbm_host.sv */
// controller end: builds a chopped write burst with appended check bits
`timescale 1ns/1ps
`include "wcbm_defines.svh"
module wcbm_host (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	output logic             o_irq,
	wcbm_if.ctrl             link
);
	typedef enum logic [0:0] {
		WCBM_H_IDLE = 1'b0,
		WCBM_H_SEND = 1'b1
	} wcbm_hstate_t;

	// ==========================================================
	// registers
	wcbm_hstate_t         state_reg;
	logic [63:0]          data_reg;
	logic [7:0]           mi_reg;
	logic [3:0]           ctrl_reg;
	logic [1:0]           status_reg;
	logic [1:0]           mask_reg;
	logic [15:0]          crc_reg;
	logic [3:0]           cnt_reg;
	wcbm_pkg::wcbm_beat_t beat_reg;
	logic                 first_reg;
	logic [31:0]          rdata_reg;

	// ==========================================================
	// decode
	wire               wr_lo   = i_wr && i_addr == `WCBM_HST_DATA_LO;
	wire               wr_hi   = i_wr && i_addr == `WCBM_HST_DATA_HI;
	wire               wr_mi   = i_wr && i_addr == `WCBM_HST_MI;
	wire               wr_ctrl = i_wr && i_addr == `WCBM_HST_CTRL;
	wire               wr_mask = i_wr && i_addr == `WCBM_HST_MASK;
	wire               rd_st   = i_rd && i_addr == `WCBM_HST_STATUS;
	wire               go      = wr_ctrl && i_wdata[`WCBM_CTRL_GO] && state_reg == WCBM_H_IDLE;
	wire wcbm_pkg::wcbm_org_t org = wcbm_pkg::wcbm_org_t'(ctrl_reg[1:0]);
	wire               mi_en   = ctrl_reg[`WCBM_CFG_MI_BIT];
	wire               half    = ctrl_reg[`WCBM_CTRL_HALF];
	wire               done    = state_reg == WCBM_H_SEND && cnt_reg == `WCBM_BURST_LAST;

	// same mapping and shift the device applies, so both trees agree
	wire wcbm_pkg::wcbm_beats_t beats = {
		{mi_reg[7], mi_reg[3], data_reg[63:48]}, {mi_reg[6], mi_reg[2], data_reg[47:32]},
		{mi_reg[5], mi_reg[1], data_reg[31:16]}, {mi_reg[4], mi_reg[0], data_reg[15:0]}};
	// a go write may also change the layout: the check byte must use the new one
	wire [3:0]   ctrl_eff = (wr_ctrl && state_reg == WCBM_H_IDLE) ? i_wdata[3:0] : ctrl_reg;
	wire [143:0] tree = wcbm_pkg::wcbm_tree_in(beats, ctrl_eff[`WCBM_CTRL_HALF],
		wcbm_pkg::wcbm_org_t'(ctrl_eff[1:0]), ctrl_eff[`WCBM_CFG_MI_BIT]);
	wire [15:0]  crc  = {wcbm_pkg::wcbm_crc8(tree[143:72]), wcbm_pkg::wcbm_crc8(tree[71:0])};

	// data in 0-3, ones in 4-7, check bits in 8-9
	wire [3:0] nxt_cnt = cnt_reg + 4'h1;
	wire wcbm_pkg::wcbm_beat_t nxt_beat =
		(nxt_cnt <= `WCBM_DATA_LAST) ? beats[nxt_cnt[1:0]] :
		(nxt_cnt < `WCBM_CRC_BEAT0) ? '1 :
		wcbm_pkg::wcbm_crc_beat(crc_reg, org, nxt_cnt == `WCBM_BURST_LAST);

	wire [31:0] rd_mux =
		(i_addr == `WCBM_HST_DATA_LO) ? data_reg[31:0] :
		(i_addr == `WCBM_HST_DATA_HI) ? data_reg[63:32] :
		(i_addr == `WCBM_HST_MI)      ? {24'h000000, mi_reg} :
		(i_addr == `WCBM_HST_CTRL)    ? {28'h0000000, ctrl_reg} :
		(i_addr == `WCBM_HST_STATUS)  ? {29'h00000000, state_reg == WCBM_H_SEND, status_reg} :
		(i_addr == `WCBM_HST_MASK)    ? {30'h00000000, mask_reg} :
		(i_addr == `WCBM_HST_CRC)     ? {16'h0000, crc_reg} : 32'h00000000;

	// set wins over the read clear
	wire [1:0] status_next = (rd_st ? 2'h0 : status_reg) | {1'b0, done};

	// ==========================================================
	// state
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			state_reg  <= WCBM_H_IDLE;
			data_reg   <= 64'h0000000000000000;
			mi_reg     <= 8'hFF;
			ctrl_reg   <= {1'b0, `WCBM_CFG_RST};
			status_reg <= 2'h0;
			mask_reg   <= `WCBM_MASK_RST;
			crc_reg    <= 16'h0000;
			cnt_reg    <= 4'h0;
			beat_reg   <= '1;
			first_reg  <= 1'b0;
			rdata_reg  <= 32'h00000000;
		end else begin
			status_reg <= status_next;
			rdata_reg  <= i_rd ? rd_mux : 32'h00000000;
			first_reg  <= go;
			if (state_reg == WCBM_H_IDLE) begin
				if (wr_lo) data_reg[31:0] <= i_wdata;
				if (wr_hi) data_reg[63:32] <= i_wdata;
				if (wr_mi) mi_reg <= i_wdata[7:0];
				if (wr_ctrl) ctrl_reg <= i_wdata[3:0];
			end
			if (wr_mask) mask_reg <= i_wdata[1:0];
			if (go) begin
				state_reg <= WCBM_H_SEND;
				cnt_reg   <= 4'h0;
				crc_reg   <= crc;
				beat_reg  <= beats[0];
			end else if (state_reg == WCBM_H_SEND) begin
				cnt_reg  <= nxt_cnt;
				// idle lanes go back to ones once the last check beat is out
				beat_reg <= done ? '1 : nxt_beat;
				if (done) state_reg <= WCBM_H_IDLE;
			end
		end
	end

	// ==========================================================
	// outputs
	assign link.link_valid                = state_reg == WCBM_H_SEND;
	assign link.link_first                = first_reg;
	assign link.burst_half_select_bit     = half;
	assign link.link_dq                   = beat_reg[15:0];
	assign link.lower_mask_inversion_lane = beat_reg[16];
	assign link.upper_mask_inversion_lane = beat_reg[17];
	assign o_rdata                        = rdata_reg;
	assign o_irq                          = |(status_reg & mask_reg);
endmodule

/* verilog/wcbm_device.sv */
// device end: maps a chopped write burst onto the check trees and verifies it
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "wcbm_defines.svh"
module wcbm_device (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	output logic             o_irq,
	output logic             o_wr_valid,
	output logic      [63:0] o_wr_data,
	output logic      [7:0]  o_wr_mi,
	output logic             o_wr_half,
	output logic             o_crc_err,
	wcbm_if.dram             link
);
	typedef enum logic [1:0] {
		WCBM_D_IDLE  = 2'b00,
		WCBM_D_RECV  = 2'b01,
		WCBM_D_CHECK = 2'b10
	} wcbm_dstate_t;

	// ==========================================================
	// registers
	wcbm_dstate_t          state_reg;
	logic [2:0]            cfg_reg;
	logic [1:0]            status_reg;
	logic [1:0]            mask_reg;
	logic [16:0]           result_reg;
	logic [3:0]            cnt_reg;
	logic                  half_reg;
	wcbm_pkg::wcbm_beats_t data_reg;
	wcbm_pkg::wcbm_beat_t  chk0_reg;
	wcbm_pkg::wcbm_beat_t  chk1_reg;
	logic                  wr_valid_reg;
	logic [63:0]           wr_data_reg;
	logic [7:0]            wr_mi_reg;
	logic                  wr_half_reg;
	logic                  crc_err_reg;
	logic [31:0]           rdata_reg;

	// ==========================================================
	// link side decode
	wire wcbm_pkg::wcbm_beat_t rx_beat = {link.upper_mask_inversion_lane,
		link.lower_mask_inversion_lane, link.link_dq};
	wire start     = state_reg == WCBM_D_IDLE && link.link_valid && link.link_first;
	wire recv_beat = state_reg == WCBM_D_RECV && link.link_valid;
	// a burst that loses its valid strobe is dropped, nothing is reported
	wire recv_lost = state_reg == WCBM_D_RECV && !link.link_valid;
	wire recv_end  = recv_beat && cnt_reg == `WCBM_BURST_LAST;

	// ==========================================================
	// configuration
	wire wcbm_pkg::wcbm_org_t org = wcbm_pkg::wcbm_org_t'(cfg_reg[1:0]);
	// masking and inversion share one enable; x4 has no such lane at all
	wire mi_en = cfg_reg[`WCBM_CFG_MI_BIT];

	// ==========================================================
	// tree inputs: live positions per organisation, ones elsewhere;
	// half 1 moves every lane's four transfers to its upper nibble
	wire [143:0] tree = wcbm_pkg::wcbm_tree_in(data_reg, half_reg,
		org, mi_en);

	// two identical trees; the upper one sees only ones unless x16
	wire [7:0] crc_lo = wcbm_pkg::wcbm_crc8(tree[71:0]);
	wire [7:0] crc_hi = wcbm_pkg::wcbm_crc8(tree[143:72]);
	wire [15:0] crc_calc = {crc_hi, crc_lo};

	// expected transfers 8 and 9 built the way the controller must send them
	wire wcbm_pkg::wcbm_beat_t exp0 = wcbm_pkg::wcbm_crc_beat(crc_calc, org, 1'b0);
	wire wcbm_pkg::wcbm_beat_t exp1 = wcbm_pkg::wcbm_crc_beat(crc_calc, org, 1'b1);
	// whole transfers compared: stray zeros in the one positions also fail
	wire mismatch = (exp0 != chk0_reg) || (exp1 != chk1_reg);
	wire checking = state_reg == WCBM_D_CHECK;

	// ==========================================================
	// register port decode
	wire wr_cfg  = i_wr && i_addr == `WCBM_DEV_CFG;
	wire wr_mask = i_wr && i_addr == `WCBM_DEV_MASK;
	wire rd_st   = i_rd && i_addr == `WCBM_DEV_STATUS;
	wire [31:0] rd_mux =
		(i_addr == `WCBM_DEV_CFG)    ? {29'h00000000, cfg_reg} :
		(i_addr == `WCBM_DEV_STATUS) ? {30'h00000000, status_reg} :
		(i_addr == `WCBM_DEV_MASK)   ? {30'h00000000, mask_reg} :
		(i_addr == `WCBM_DEV_RESULT) ? {15'h0000, result_reg} : 32'h00000000;

	// events: a good write and a check error; set wins over the read clear
	wire [1:0] set_bits    = {checking && mismatch, checking && !mismatch};
	wire [1:0] status_next = (rd_st ? 2'h0 : status_reg) | set_bits;

	// per-beat unpack of received data for the core side
	wire [63:0] data_flat = {data_reg[3][15:0], data_reg[2][15:0],
		data_reg[1][15:0], data_reg[0][15:0]};
	wire [7:0] mi_flat = {data_reg[3][17], data_reg[2][17], data_reg[1][17], data_reg[0][17],
		data_reg[3][16], data_reg[2][16], data_reg[1][16], data_reg[0][16]};

	// ==========================================================
	// receive sequencer
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			state_reg <= WCBM_D_IDLE;
			cnt_reg   <= 4'h0;
			half_reg  <= 1'b0;
			data_reg  <= '1;
			chk0_reg  <= '1;
			chk1_reg  <= '1;
		end else begin
			unique case (state_reg)
				WCBM_D_IDLE: begin
					if (start) begin
						state_reg   <= WCBM_D_RECV;
						cnt_reg     <= 4'h1;
						half_reg    <= link.burst_half_select_bit;
						data_reg[0] <= rx_beat;
					end
				end
				WCBM_D_RECV: begin
					if (recv_lost) begin
						state_reg <= WCBM_D_IDLE;
					end else begin
						cnt_reg <= cnt_reg + 4'h1;
						if (cnt_reg <= `WCBM_DATA_LAST) data_reg[cnt_reg[1:0]] <= rx_beat;
						if (cnt_reg == `WCBM_CRC_BEAT0) chk0_reg <= rx_beat;
						if (recv_end) begin
							chk1_reg  <= rx_beat;
							state_reg <= WCBM_D_CHECK;
						end
					end
				end
				WCBM_D_CHECK: begin
					state_reg <= WCBM_D_IDLE;
				end
				default: begin
					state_reg <= WCBM_D_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// result and core-side write; a failed check blocks the write
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_valid_reg <= 1'b0;
			wr_data_reg  <= 64'h0000000000000000;
			wr_mi_reg    <= 8'hFF;
			wr_half_reg  <= 1'b0;
			crc_err_reg  <= 1'b0;
			result_reg   <= 17'h00000;
		end else begin
			wr_valid_reg <= checking && !mismatch;
			crc_err_reg  <= checking && mismatch;
			if (checking) begin
				wr_data_reg <= data_flat;
				wr_mi_reg   <= mi_flat;
				wr_half_reg <= half_reg;
				result_reg  <= {half_reg, crc_calc};
			end
		end
	end

	// ==========================================================
	// register port
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			cfg_reg    <= `WCBM_CFG_RST;
			mask_reg   <= `WCBM_MASK_RST;
			status_reg <= 2'h0;
			rdata_reg  <= 32'h00000000;
		end else begin
			status_reg <= status_next;
			rdata_reg  <= i_rd ? rd_mux : 32'h00000000;
			// configuration writes are refused from the second transfer of a burst until its check is done; one in the first transfer's cycle still lands
			if (wr_cfg && state_reg == WCBM_D_IDLE) cfg_reg <= i_wdata[2:0];
			if (wr_mask) mask_reg <= i_wdata[1:0];
		end
	end

	// ==========================================================
	// outputs
	assign o_rdata    = rdata_reg;
	assign o_irq      = |(status_reg & mask_reg);
	assign o_wr_valid = wr_valid_reg;
	assign o_wr_data  = wr_data_reg;
	assign o_wr_mi    = wr_mi_reg;
	assign o_wr_half  = wr_half_reg;
	assign o_crc_err  = crc_err_reg;
endmodule

/* tb/wcbm_link_monitor.sv */
// concurrent checks on the write burst link between the two ends
`timescale 1ns/1ps
module wcbm_link_monitor (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	input  wire logic        link_valid,
	input  wire logic        link_first,
	input  wire logic        burst_half_select_bit,
	input  wire logic [15:0] link_dq,
	input  wire logic        lower_mask_inversion_lane,
	input  wire logic        upper_mask_inversion_lane
);
	// ==========================================================
	// lane groups
	wire all_ones = &{upper_mask_inversion_lane, lower_mask_inversion_lane, link_dq};
	wire hi_ones  = &{upper_mask_inversion_lane, lower_mask_inversion_lane, link_dq[15:4]};
	wire mi_ones  = lower_mask_inversion_lane && upper_mask_inversion_lane;

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_rst);

	// ==========================================================
	// frame shape
	sequence s_frame;
		link_valid [*8] ##1 link_valid [*2] ##1 !link_valid;
	endsequence
	sequence s_pad;
		all_ones [*4];
	endsequence

	chk_first_valid: assert property (link_first |-> link_valid)
		else $error("first transfer flagged without valid");
	chk_frame_len: assert property (link_first |-> s_frame)
		else $error("burst is not ten transfers long");
	chk_pad_ones: assert property (link_first |-> ##4 s_pad)
		else $error("transfers four to seven not all ones");
	chk_beat8_lanes: assert property (link_first |-> ##8 mi_ones)
		else $error("mask lanes not one in transfer eight");
	chk_beat9_ones: assert property (link_first |-> ##9 hi_ones)
		else $error("transfer nine carries zeros above lane three");
	chk_half_steady: assert property (link_valid && !link_first |-> $stable(burst_half_select_bit))
		else $error("half select moved inside a burst");
	chk_first_once: assert property (link_first |=> (!link_first) [*8] ##1 !link_first)
		else $error("second first-transfer flag inside a burst");
	chk_gap_before: assert property ($fell(link_valid) |->
		$past(link_first, 10) && !$past(link_valid, 11))
		else $error("burst ended without a clean start ten cycles back");
endmodule

/* tb/tb_top.sv */
// self-checking bench: controller end and device end joined over the link
`timescale 1ns/1ps
`include "wcbm_defines.svh"
module tb_top;
	typedef struct {
		logic        err;
		logic [63:0] dat;
		logic [7:0]  mi;
		logic        half;
		logic [17:0] b8;
		logic [17:0] b9;
	} wcbm_rnote_t;
	typedef struct {
		logic        dev;
		logic [31:0] exp;
		logic [31:0] msk;
	} wcbm_rdnote_t;

	logic         clk;
	logic         rst;
	logic [7:0]   h_addr;
	logic [7:0]   d_addr;
	logic [31:0]  h_wdata;
	logic [31:0]  d_wdata;
	logic         h_wr;
	logic         h_rd;
	logic         d_wr;
	logic         d_rd;
	logic [31:0]  h_rdata;
	logic [31:0]  d_rdata;
	logic         h_irq;
	logic         d_irq;
	logic         wr_valid;
	logic         wr_half;
	logic         crc_err;
	logic [63:0]  wr_data;
	logic [7:0]   wr_mi;
	logic [17:0]  cap8;
	logic [17:0]  cap9;
	logic [1:0]   rd_pipe;
	int           lcnt;
	int           n_mismatch;
	int           samples_checked;
	bit           irq_on;
	wcbm_rnote_t  rn;
	wcbm_rdnote_t rdn;
	wcbm_rnote_t  res_q[$];
	wcbm_rdnote_t rd_q[$];

	wcbm_if lk();
	wcbm_host u_wcbm_host (.i_core_clk(clk), .i_rst(rst), .i_addr(h_addr), .i_wdata(h_wdata),
		.i_wr(h_wr), .i_rd(h_rd), .o_rdata(h_rdata), .o_irq(h_irq), .link(lk));
	wcbm_device u_wcbm_device (.i_core_clk(clk), .i_rst(rst), .i_addr(d_addr), .i_wdata(d_wdata),
		.i_wr(d_wr), .i_rd(d_rd), .o_rdata(d_rdata), .o_irq(d_irq), .o_wr_valid(wr_valid),
		.o_wr_data(wr_data), .o_wr_mi(wr_mi), .o_wr_half(wr_half), .o_crc_err(crc_err), .link(lk));
	wcbm_link_monitor u_wcbm_link_monitor (.i_core_clk(clk), .i_rst(rst),
		.link_valid(lk.link_valid), .link_first(lk.link_first),
		.burst_half_select_bit(lk.burst_half_select_bit), .link_dq(lk.link_dq),
		.lower_mask_inversion_lane(lk.lower_mask_inversion_lane),
		.upper_mask_inversion_lane(lk.upper_mask_inversion_lane));

	always #2 clk = ~clk;

	// ==========================================================
	// reporting
	task automatic report_and_stop();
		if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// ==========================================================
	// reference model of the chopped mapping and check byte
	function automatic logic [7:0] crc8(input logic [71:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 71; i >= 0; i--) c = {c[6:0], 1'h0} ^ (8'h07 & {8{c[7] ^ d[i]}});
		return c;
	endfunction
	function automatic logic [15:0] crc_exp(input logic [63:0] dat, input logic [7:0] mi,
			input int org, input bit me, input bit h);
		logic [143:0] d;
		d = '1;
		for (int t = 0; t < 4; t++) begin
			for (int l = 0; l < 16; l++) begin
				if (org == 2 || (org == 1 && l < 8) || l < 4) begin
					d[(l / 8) * 72 + (l % 8) * 8 + h * 4 + t] = dat[16 * t + l];
				end
			end
			if (me && org != 0) d[64 + h * 4 + t] = mi[t];
			if (me && org == 2) d[136 + h * 4 + t] = mi[4 + t];
		end
		return {crc8(d[143:72]), crc8(d[71:0])};
	endfunction
	function automatic logic [17:0] beat_exp(input logic [15:0] c, input int org, input bit sec);
		logic [17:0] b;
		b = '1;
		if (org == 0) b[3:0] = sec ? c[7:4] : c[3:0];
		else if (!sec) begin
			b[7:0] = c[7:0];
			if (org == 2) b[15:8] = c[15:8];
		end
		return b;
	endfunction

	// ==========================================================
	// register port cycles; a gap cycle keeps each strobe one cycle long
	task automatic bus(input bit dev, input bit rd, input logic [7:0] a, input logic [31:0] v,
			input logic [31:0] m);
		wcbm_rdnote_t n;
		@(posedge clk);
		if (dev) begin
			d_addr <= a; d_wdata <= v; d_wr <= !rd; d_rd <= rd;
		end else begin
			h_addr <= a; h_wdata <= v; h_wr <= !rd; h_rd <= rd;
		end
		if (rd) begin
			n.dev = dev; n.exp = v; n.msk = m; rd_q.push_back(n);
		end
		@(posedge clk);
		d_wr <= 1'h0; d_rd <= 1'h0; h_wr <= 1'h0; h_rd <= 1'h0;
	endtask

	task automatic burst(input int org, input bit me, input bit h, input bit dme, input bit err);
		logic [63:0] dat;
		logic [7:0]  mi;
		logic [15:0] c;
		logic [31:0] ctl;
		wcbm_rnote_t n;
		int          k;
		dat = {$urandom, $urandom};
		mi = err ? 8'h00 : 8'($urandom);
		ctl = {28'h0, h, me, 2'(org)};
		c = crc_exp(dat, mi, org, me, h);
		n = '{err, dat, mi, h, beat_exp(c, org, 1'h0), beat_exp(c, org, 1'h1)};
		bus(1, 0, `WCBM_DEV_CFG, {29'h0, dme, 2'(org)}, 32'h0);
		bus(0, 0, `WCBM_HST_DATA_LO, dat[31:0], 32'h0);
		bus(0, 0, `WCBM_HST_DATA_HI, dat[63:32], 32'h0);
		bus(0, 0, `WCBM_HST_MI, {24'h0, mi}, 32'h0);
		bus(0, 0, `WCBM_HST_CTRL, ctl, 32'h0);
		res_q.push_back(n);
		bus(0, 0, `WCBM_HST_CTRL, ctl | 32'h10, 32'h0);
		k = 0;
		while (res_q.size() != 0 && k < 40) begin
			@(posedge clk);
			k++;
		end
		if (k == 40) begin
			n_mismatch++;
			report_and_stop();
		end
		@(negedge clk);
		chk("dev_irq", irq_on, d_irq);
		chk("host_irq", irq_on, h_irq);
		if (!err) bus(1, 1, `WCBM_DEV_RESULT, {15'h0, h, c}, 32'h1FFFF);
		bus(1, 1, `WCBM_DEV_STATUS, err ? 32'h2 : 32'h1, 32'h3);
		bus(0, 1, `WCBM_HST_STATUS, 32'h1, 32'h1);
		bus(0, 1, `WCBM_HST_CRC, {16'h0, c}, 32'hFFFF);
		repeat (2) @(negedge clk);
		chk("dev_irq_clear", 0, d_irq);
		chk("host_irq_clear", 0, h_irq);
	endtask

	// ==========================================================
	// watchers: link capture, burst results, read data
	always @(posedge clk) rd_pipe <= {d_rd, h_rd};
	always @(negedge clk) begin
		if (lk.link_valid === 1'h1) begin
			lcnt = (lk.link_first === 1'h1) ? 0 : lcnt + 1;
			if (lcnt == 8) cap8 = {lk.upper_mask_inversion_lane, lk.lower_mask_inversion_lane, lk.link_dq};
			if (lcnt == 9) cap9 = {lk.upper_mask_inversion_lane, lk.lower_mask_inversion_lane, lk.link_dq};
		end
		if (wr_valid === 1'h1 || crc_err === 1'h1) begin
			if (res_q.size() == 0) chk("unexpected_result", 1, 0);
			else begin
				rn = res_q.pop_front();
				chk("crc_err", rn.err, crc_err);
				chk("beat8", rn.b8, cap8);
				chk("beat9", rn.b9, cap9);
				if (!rn.err) begin
					chk("wr_data", rn.dat, wr_data);
					chk("wr_mi", rn.mi, wr_mi);
					chk("wr_half", rn.half, wr_half);
				end
			end
		end
		if (rd_pipe != 2'h0) begin
			if (rd_q.size() == 0) chk("unexpected_read", 1, 0);
			else begin
				rdn = rd_q.pop_front();
				chk("rdata", rdn.exp, (rdn.dev ? d_rdata : h_rdata) & rdn.msk);
			end
		end
	end

	// ==========================================================
	// main sequence
	initial begin
		clk = 1'h0; rst = 1'h1; h_addr = 8'h00; d_addr = 8'h00; h_wdata = 32'h0; d_wdata = 32'h0;
		h_wr = 1'h0; h_rd = 1'h0; d_wr = 1'h0; d_rd = 1'h0;
		n_mismatch = 0; samples_checked = 0; irq_on = 0; lcnt = 0; cap8 = '0; cap9 = '0;
		void'($urandom(23935));
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		bus(1, 1, `WCBM_DEV_CFG, 32'h1, 32'h7);
		bus(1, 1, `WCBM_DEV_MASK, 32'h0, 32'h3);
		bus(0, 1, `WCBM_HST_MI, 32'hFF, 32'hFF);
		bus(1, 1, 8'h40, 32'h0, 32'hFFFFFFFF);
		burst(1, 0, 0, 0, 0);
		bus(1, 0, `WCBM_DEV_MASK, 32'h3, 32'h0);
		bus(0, 0, `WCBM_HST_MASK, 32'h1, 32'h0);
		irq_on = 1;
		for (int o = 0; o < 3; o++) begin
			for (int m = 0; m < 2; m++) begin
				for (int h = 0; h < 2; h++) burst(o, m, h, m, 0);
			end
		end
		// lane sent live while the device expects ones: must be refused
		burst(1, 1, 0, 0, 1);
		burst(2, 1, 1, 0, 1);
		report_and_stop();
	end
endmodule
